// ### timer16_counter_ch0.sv
// How it works
// R1 - Reading the counter low byte latches the upper counter byte into the snapshot.
// R2 - Any write to the counter low byte clears the whole counter to zero.
// R3 - Status bits 7, 6, 5 are sticky flags for channels two, one, zero.
// R4 - Wrap flag bit 4 sets on terminal count, or zero reached counting down.
// R5 - Writing 0 to a flag clears it; writing 1 leaves it.
// R6 - Prescaler bits 3:2 divide the tick by 1, 8, 32 or 128.
// R7 - Mode 00 holds the counter still.
// R8 - Mode 01 counts from zero to 0xffff and wraps, repeatedly.
// R9 - Mode 10 counts from zero to the channel value and restarts.
// R10 - Mode 11 counts up to the channel value, then down to zero.
// R11 - Compare codes 000, 001, 010 set, clear, toggle the output on match.
// R12 - Code 011 sets on up-match, clears at zero or on down-match.
// R13 - Code 100 clears on up-match, sets at zero or on down-match.
// R14 - Channel control bit 2 picks capture (0) or compare (1).
// R15 - Edge select picks none, rising, falling or both edges for capture.
// R16 - Channel control bit 6 is the interrupt mask, reset to 1.
// R17 - Software always writes 0 to reserved channel control bit 7.
// R18 - Channel value is 16 bits as two byte registers, reset zero.
// R19 - Channel value low byte is buffered until the high byte is written.
// R20 - A selected input edge copies the counter into the channel value, sets flag.
// R21 - Counter advances once per cycle, only with tick and prescaler both active.
`timescale 1ns/1ps
`include "timer16_regs.svh"
module timer16_counter_ch0
    import timer16_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic tick_en,
    input wire logic [1:0] other_chan_events,
    input wire logic chan_in,
    output logic chan_out,
    output logic chan_oe,
    output logic chan_zero_req
);

    logic adv;
    logic step;
    logic rd_acc;
    logic [7:0] rd_idx;
    logic [7:0] rd_mux;
    logic [7:0] wdata;
    logic dvalid_r;
    bus_phase_type dphase_r;
    logic [31:0] hrdata_r;
    logic we_val_low;
    logic we_val_high;
    logic we_count_low;
    logic we_ctl;
    logic we_cctl;
    logic [15:0] count_r;
    logic [15:0] count_nxt;
    logic up_r;
    logic up_nxt;
    logic down_move;
    logic wrap_evt;
    logic match_evt;
    logic match_up;
    logic match_down;
    logic zero_evt;
    logic [7:0] snapshot_r;
    logic [15:0] cc0_r;
    logic [7:0] val_low_buf_r;
    timer_cfg_type cfg_r;
    chan_ctrl_type cctl_r;
    logic [3:0] flags_r;
    logic [3:0] flag_set;
    logic [3:0] flag_clr;
    logic in_s1_r;
    logic in_s2_r;
    logic in_s3_r;
    logic rise;
    logic fall;
    logic cap_evt;
    logic chan_evt;
    logic out_r;

    // Zero-wait slave: every transfer completes in one data phase with OKAY.
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = hrdata_r;

    assign rd_acc = hsel && htrans[1] && hready && !hwrite;
    assign rd_idx = haddr[`HADDR_IDX_MSB:`HADDR_IDX_LSB];
    assign wdata = hwdata[7:0];

    // Holds the address phase of a write for use in its data phase.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dvalid_r <= 1'b0;
            dphase_r <= '0;
        end else begin
            dvalid_r <= hsel && htrans[1] && hready && hwrite;
            dphase_r <= '{idx: rd_idx, wr: hwrite};
        end
    end

    assign we_val_low = dvalid_r && dphase_r.idx == `IDX_CHAN_VALUE_LOW;
    assign we_val_high = dvalid_r && dphase_r.idx == `IDX_CHAN_VALUE_HIGH;
    assign we_count_low = dvalid_r && dphase_r.idx == `IDX_COUNT_LOW;
    assign we_ctl = dvalid_r && dphase_r.idx == `IDX_CONTROL_STATUS;
    assign we_cctl = dvalid_r && dphase_r.idx == `IDX_CHAN_CONTROL;

    // Read multiplexer; unmapped indices read as zero.
    always_comb begin
        case (rd_idx)
            `IDX_CHAN_VALUE_LOW: rd_mux = cc0_r[7:0];
            `IDX_CHAN_VALUE_HIGH: rd_mux = cc0_r[15:8];
            `IDX_COUNT_LOW: rd_mux = count_r[7:0];
            `IDX_COUNT_HIGH: rd_mux = snapshot_r;
            `IDX_CONTROL_STATUS: rd_mux = {flags_r, cfg_r};
            `IDX_CHAN_CONTROL: rd_mux = {1'b0, cctl_r};
            default: rd_mux = `BYTE_RESET;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata_r <= '0;
        end else if (rd_acc) begin
            hrdata_r <= {{24{1'b0}}, rd_mux};
        end
    end

    // The snapshot keeps the upper byte coherent with the low byte just read.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            snapshot_r <= `BYTE_RESET;
        end else if (rd_acc && rd_idx == `IDX_COUNT_LOW) begin
            snapshot_r <= count_r[15:8]; // R1
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cfg_r <= `CFG_RESET;
        end else if (we_ctl) begin
            cfg_r <= wdata[`CTL_CFG_MSB:`CTL_CFG_LSB]; // R6
        end
    end

    // Bit 7 is not stored, so it reads as zero whatever software writes.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cctl_r <= `CCTL_RESET; // R16
        end else if (we_cctl) begin
            cctl_r <= wdata[`CCTL_MSB:`CCTL_LSB]; // R14 R15 R17
        end
    end

    timer16_prescaler #(
        .PRESCALE_WIDTH(7)
    ) u_prescaler (
        .hclk(hclk),
        .hresetn(hresetn),
        .tick_en(tick_en),
        .div_sel(cfg_r.div_sel),
        .advance(adv)
    );

    assign step = adv && (cfg_r.mode != MODE_SUSPEND) && !we_count_low; // R7 R21

    // Next counter value and direction for each mode.
    always_comb begin
        count_nxt = count_r;
        up_nxt = up_r;
        down_move = 1'b0;
        wrap_evt = 1'b0;
        if (step) begin
            case (cfg_r.mode)
                MODE_FREE: begin
                    count_nxt = count_r + `COUNT_ONE; // R8
                    up_nxt = 1'b1;
                    wrap_evt = (count_r == `COUNT_FULL); // R4
                end
                MODE_MODULO: begin
                    up_nxt = 1'b1;
                    if (count_r >= cc0_r) begin
                        count_nxt = `COUNT_ZERO; // R9
                        wrap_evt = 1'b1; // R4
                    end else begin
                        count_nxt = count_r + `COUNT_ONE;
                    end
                end
                MODE_UPDOWN: begin
                    if (up_r && count_r < cc0_r) begin
                        count_nxt = count_r + `COUNT_ONE; // R10
                    end else if (count_r == `COUNT_ZERO) begin
                        up_nxt = 1'b1;
                        count_nxt = (cc0_r == `COUNT_ZERO) ? `COUNT_ZERO : `COUNT_ONE;
                    end else begin
                        up_nxt = 1'b0;
                        down_move = 1'b1;
                        count_nxt = count_r - `COUNT_ONE; // R10
                        wrap_evt = (count_r == `COUNT_ONE); // R4
                    end
                end
                default: begin
                    count_nxt = count_r;
                end
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            count_r <= `COUNT_ZERO;
            up_r <= 1'b1;
        end else if (we_count_low) begin
            count_r <= `COUNT_ZERO; // R2
            up_r <= 1'b1;
        end else begin
            count_r <= count_nxt;
            up_r <= up_nxt;
        end
    end

    assign match_evt = step && (count_nxt == cc0_r);
    assign match_up = match_evt && !down_move;
    assign match_down = match_evt && down_move;
    assign zero_evt = step && (count_nxt == `COUNT_ZERO);

    // Input synchroniser; the second and third stages feed the edge detector.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            in_s1_r <= 1'b0;
            in_s2_r <= 1'b0;
            in_s3_r <= 1'b0;
        end else begin
            in_s1_r <= chan_in;
            in_s2_r <= in_s1_r;
            in_s3_r <= in_s2_r;
        end
    end

    assign rise = in_s2_r && !in_s3_r;
    assign fall = !in_s2_r && in_s3_r;

    always_comb begin
        case (cctl_r.edge_select)
            EDGE_RISE: cap_evt = rise; // R15
            EDGE_FALL: cap_evt = fall; // R15
            EDGE_BOTH: cap_evt = rise || fall; // R15
            default: cap_evt = 1'b0;
        endcase
        cap_evt = cap_evt && !cctl_r.compare_op; // R14
    end

    // Channel value; a capture wins over a software commit in the same cycle.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cc0_r <= {`BYTE_RESET, `BYTE_RESET}; // R18
            val_low_buf_r <= `BYTE_RESET;
        end else begin
            if (we_val_low) begin
                val_low_buf_r <= wdata; // R19
            end
            if (cap_evt) begin
                cc0_r <= count_r; // R20
            end else if (we_val_high) begin
                cc0_r <= {wdata, val_low_buf_r}; // R19
            end
        end
    end

    // In up/down mode the channel event is the return to zero instead of a match.
    assign chan_evt = cap_evt || (cctl_r.compare_op &&
        ((cfg_r.mode == MODE_UPDOWN) ? (zero_evt && down_move) : match_evt)); // R20

    always_comb begin
        flag_set = `FLAGS_RESET;
        flag_set[`FLAG_IDX_CH2] = other_chan_events[1]; // R3
        flag_set[`FLAG_IDX_CH1] = other_chan_events[0]; // R3
        flag_set[`FLAG_IDX_CH0] = chan_evt; // R3
        flag_set[`FLAG_IDX_WRAP] = wrap_evt; // R4
        flag_clr = we_ctl ? ~wdata[`CTL_FLAGS_MSB:`CTL_FLAGS_LSB] : `FLAGS_RESET; // R5
    end

    // A set in the same cycle as a clear wins.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            flags_r <= `FLAGS_RESET;
        end else begin
            flags_r <= (flags_r & ~flag_clr) | flag_set; // R3 R5
        end
    end

    // Compare output; registered so every edge on the pin is glitch-free.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            out_r <= 1'b0;
        end else if (cctl_r.compare_op) begin
            case (cctl_r.compare_action_select)
                CMP_SET: begin
                    if (match_evt) out_r <= 1'b1; // R11
                end
                CMP_CLEAR: begin
                    if (match_evt) out_r <= 1'b0; // R11
                end
                CMP_TOGGLE: begin
                    if (match_evt) out_r <= !out_r; // R11
                end
                CMP_SET_UP: begin
                    if (match_up) out_r <= 1'b1; // R12
                    else if (zero_evt || match_down) out_r <= 1'b0; // R12
                end
                CMP_CLEAR_UP: begin
                    if (match_up) out_r <= 1'b0; // R13
                    else if (zero_evt || match_down) out_r <= 1'b1; // R13
                end
                default: begin
                    out_r <= out_r;
                end
            endcase
        end
    end

    assign chan_out = out_r;
    assign chan_oe = cctl_r.compare_op; // R14
    assign chan_zero_req = flags_r[`FLAG_IDX_CH0] && cctl_r.chan_irq_mask; // R16

    default clocking dflt_cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    sequence low_read_s;
        rd_acc && rd_idx == `IDX_COUNT_LOW;
    endsequence

    sequence value_low_write_s;
        we_val_low && !cap_evt;
    endsequence

    sequence value_high_write_s;
        we_val_high && !we_val_low && !cap_evt;
    endsequence

    snapshot_latch_a: assert property (low_read_s |=> snapshot_r == $past(count_r[15:8])) // R1
        else $error("snapshot does not hold counter high byte");

    count_clear_a: assert property (we_count_low |=> count_r == `COUNT_ZERO) // R2
        else $error("counter not cleared by low byte write");

    chan_flag_set_a: assert property (chan_evt |=> flags_r[`FLAG_IDX_CH0]) // R3
        else $error("channel flag not set by channel event");

    wrap_flag_set_a: assert property (wrap_evt |=> flags_r[`FLAG_IDX_WRAP]) // R4
        else $error("wrap flag not set on terminal count");

    flag_clear_a: assert property (we_ctl && !wdata[`CTL_FLAGS_LSB] && !wrap_evt // R5
        |=> !flags_r[`FLAG_IDX_WRAP])
        else $error("writing zero did not clear wrap flag");

    flag_keep_a: assert property (we_ctl && flags_r[`FLAG_IDX_CH0] // R5
        && wdata[`CTL_FLAGS_LSB + `FLAG_IDX_CH0] |=> flags_r[`FLAG_IDX_CH0])
        else $error("flag lost by control write");

    step_gate_a: assert property (step |-> tick_en && adv) // R21
        else $error("counter advanced without tick and prescaler");

    suspend_hold_a: assert property (cfg_r.mode == MODE_SUSPEND && !we_count_low // R7
        |=> count_r == $past(count_r))
        else $error("counter moved while suspended");

    free_wrap_a: assert property (step && cfg_r.mode == MODE_FREE // R8
        && count_r == `COUNT_FULL |=> count_r == `COUNT_ZERO && flags_r[`FLAG_IDX_WRAP])
        else $error("free running counter did not wrap to zero");

    modulo_restart_a: assert property (step && cfg_r.mode == MODE_MODULO // R9
        && count_r >= cc0_r |=> count_r == `COUNT_ZERO)
        else $error("modulo counter did not restart");

    updown_turn_a: assert property (step && cfg_r.mode == MODE_UPDOWN && up_r // R10
        && count_r == cc0_r && count_r != `COUNT_ZERO
        |=> !up_r && count_r == $past(cc0_r) - `COUNT_ONE)
        else $error("up/down counter did not turn at the channel value");

    toggle_out_a: assert property (cctl_r.compare_op // R11
        && cctl_r.compare_action_select == CMP_TOGGLE && match_evt
        |=> chan_out != $past(chan_out))
        else $error("output did not toggle on match");

    capture_copy_a: assert property (cap_evt |=> cc0_r == $past(count_r)) // R20
        else $error("capture did not copy the counter");

    buffered_value_a: assert property (value_high_write_s // R19
        |=> cc0_r == {$past(wdata), $past(val_low_buf_r)})
        else $error("channel value commit does not join buffered bytes");

    low_only_a: assert property (value_low_write_s |=> cc0_r == $past(cc0_r)) // R19
        else $error("low byte write changed the channel value");

endmodule

// ### timer16_regs.svh
`ifndef TIMER16_REGS_SVH
`define TIMER16_REGS_SVH

// Register indices; the byte address is four times the index.
`define IDX_CHAN_VALUE_LOW 8'hda
`define IDX_CHAN_VALUE_HIGH 8'hdb
`define IDX_COUNT_LOW 8'he2
`define IDX_COUNT_HIGH 8'he3
`define IDX_CONTROL_STATUS 8'he4
`define IDX_CHAN_CONTROL 8'he5

// Word address field of haddr that carries the index.
`define HADDR_IDX_MSB 9
`define HADDR_IDX_LSB 2

// Control/status fields.
`define CTL_FLAGS_MSB 7
`define CTL_FLAGS_LSB 4
`define CTL_CFG_MSB 3
`define CTL_CFG_LSB 0
`define FLAG_IDX_CH2 3
`define FLAG_IDX_CH1 2
`define FLAG_IDX_CH0 1
`define FLAG_IDX_WRAP 0

// Channel control fields.
`define CCTL_MSB 6
`define CCTL_LSB 0

// Reset values.
`define BYTE_RESET 8'h00
`define FLAGS_RESET 4'h0
`define CFG_RESET 4'h0
`define CCTL_RESET 7'h40
`define COUNT_ZERO 16'h0000
`define COUNT_FULL 16'hffff
`define COUNT_ONE 16'h0001

// Prescaler terminal counts for divide by 1, 8, 32 and 128.
`define DIV_LIM_1 7'h00
`define DIV_LIM_8 7'h07
`define DIV_LIM_32 7'h1f
`define DIV_LIM_128 7'h7f

`endif

// ### timer16_pkg.sv
package timer16_pkg;

    typedef enum logic [1:0] {
        MODE_SUSPEND = 2'h0,
        MODE_FREE = 2'h1,
        MODE_MODULO = 2'h2,
        MODE_UPDOWN = 2'h3
    } timer_mode_type;

    typedef enum logic [2:0] {
        CMP_SET = 3'h0,
        CMP_CLEAR = 3'h1,
        CMP_TOGGLE = 3'h2,
        CMP_SET_UP = 3'h3,
        CMP_CLEAR_UP = 3'h4
    } compare_action_type;

    typedef enum logic [1:0] {
        EDGE_NONE = 2'h0,
        EDGE_RISE = 2'h1,
        EDGE_FALL = 2'h2,
        EDGE_BOTH = 2'h3
    } edge_select_type;

    typedef struct packed {
        logic chan_irq_mask;
        logic [2:0] compare_action_select;
        logic compare_op;
        logic [1:0] edge_select;
    } chan_ctrl_type;

    typedef struct packed {
        logic [1:0] div_sel;
        logic [1:0] mode;
    } timer_cfg_type;

    typedef struct packed {
        logic [7:0] idx;
        logic wr;
    } bus_phase_type;

endpackage

// ### timer16_prescaler.sv
`timescale 1ns/1ps
`include "timer16_regs.svh"
module timer16_prescaler
    import timer16_pkg::*;
#(
    parameter int PRESCALE_WIDTH = 7
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic tick_en,
    input wire logic [1:0] div_sel,
    output logic advance
);

    // Refuses a divider too narrow to reach the largest terminal count.
    if (PRESCALE_WIDTH < $bits(`DIV_LIM_128)) begin : g_width_check
        $error("PRESCALE_WIDTH must hold a count of 127");
    end

    logic [PRESCALE_WIDTH-1:0] div_cnt_r;
    logic [PRESCALE_WIDTH-1:0] limit;

    // Selects the terminal count of the tick divider.
    always_comb begin
        case (div_sel)
            2'h0: limit = PRESCALE_WIDTH'(`DIV_LIM_1); // R6
            2'h1: limit = PRESCALE_WIDTH'(`DIV_LIM_8); // R6
            2'h2: limit = PRESCALE_WIDTH'(`DIV_LIM_32); // R6
            default: limit = PRESCALE_WIDTH'(`DIV_LIM_128); // R6
        endcase
    end

    // Counts ticks and restarts when the limit is reached or passed.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            div_cnt_r <= '0;
        end else if (tick_en) begin
            if (div_cnt_r >= limit) begin
                div_cnt_r <= '0;
            end else begin
                div_cnt_r <= div_cnt_r + PRESCALE_WIDTH'(1);
            end
        end
    end

    assign advance = tick_en && (div_cnt_r >= limit); // R21

endmodule

// ### timer16_counter_ch0_tb.sv
`timescale 1ns/1ps
`include "timer16_regs.svh"
module timer16_counter_ch0_tb
    import timer16_pkg::*;
;
    logic hclk = 1'h0;
    logic hresetn = 1'h0;
    logic hsel = 1'h0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'h0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    logic tick_en = 1'h0;
    logic [1:0] other_chan_events = 2'h0;
    logic chan_in = 1'h0;
    logic chan_out;
    logic chan_oe;
    logic chan_zero_req;
    int fails = 0;
    int check_count = 0;
    int cycles = 0;
    logic [7:0] rd;
    int dv[4] = '{1, 8, 32, 128};
    logic [2:0] codes[7] = '{3'h0, 3'h1, 3'h2, 3'h2, 3'h3, 3'h4, 3'h5};
    logic [6:0] e1 = 7'h55;
    logic [6:0] e2 = 7'h65;

    timer16_counter_ch0 dut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .tick_en(tick_en),
        .other_chan_events(other_chan_events), .chan_in(chan_in), .chan_out(chan_out),
        .chan_oe(chan_oe), .chan_zero_req(chan_zero_req)
    );

    initial begin
        forever #10 hclk = ~hclk;
    end

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    always @(posedge hclk) begin
        cycles <= cycles + 1;
        if (cycles == 90000) begin
            fails = fails + 1;
            wrap_up();
        end
    end

    task automatic cmp(input string name, input logic [7:0] exp, input logic [7:0] got);
        check_count++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic cbit(input string name, input logic exp, input logic got);
        check_count++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] %s expected %b seen %b", name, exp, got);
        end
    endtask

    // One single AHB transfer; the address phase is held until hready is seen high.
    task automatic xfer(input logic w, input logic [7:0] idx, input logic [7:0] d);
        @(posedge hclk);
        hsel <= 1'h1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {22'h0, idx, 2'h0};
        @(posedge hclk);
        while (hreadyout !== 1'h1) @(posedge hclk);
        htrans <= 2'h0;
        hwdata <= {24'h0, d};
        @(posedge hclk);
        while (hreadyout !== 1'h1) @(posedge hclk);
        rd = hrdata[7:0];
        @(negedge hclk);
    endtask

    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        xfer(1'h1, idx, d);
    endtask

    task automatic rc(input string name, input logic [7:0] idx, input logic [7:0] exp);
        xfer(1'h0, idx, 8'h00);
        cmp(name, exp, rd);
    endtask

    // Holds the tick enable for exactly n sampling edges.
    task automatic tick(input int n);
        @(posedge hclk);
        tick_en <= 1'h1;
        repeat (n) @(posedge hclk);
        tick_en <= 1'h0;
        @(negedge hclk);
    endtask

    initial begin
        repeat (5) @(posedge hclk);
        hresetn <= 1'h1;
        rc("value_low", `IDX_CHAN_VALUE_LOW, 8'h00);
        rc("value_high", `IDX_CHAN_VALUE_HIGH, 8'h00);
        rc("count_low", `IDX_COUNT_LOW, 8'h00);
        rc("count_high", `IDX_COUNT_HIGH, 8'h00);
        rc("ctl", `IDX_CONTROL_STATUS, 8'h00);
        rc("cctl", `IDX_CHAN_CONTROL, 8'h40);
        rc("unmapped", 8'h00, 8'h00);
        cbit("chan_oe", 1'h0, chan_oe);
        cbit("hresp", 1'h0, hresp);
        cbit("hreadyout", 1'h1, hreadyout);
        $display("done: reset values");
        wr(`IDX_CHAN_VALUE_LOW, 8'h34);
        rc("value_low_held", `IDX_CHAN_VALUE_LOW, 8'h00);
        wr(`IDX_CHAN_VALUE_HIGH, 8'h12);
        rc("value_low", `IDX_CHAN_VALUE_LOW, 8'h34);
        rc("value_high", `IDX_CHAN_VALUE_HIGH, 8'h12);
        $display("done: channel value");
        wr(`IDX_COUNT_LOW, 8'ha5);
        tick(128);
        rc("count_low", `IDX_COUNT_LOW, 8'h00);
        for (int i = 0; i < 4; i++) begin
            wr(`IDX_CONTROL_STATUS, {4'h0, i[1:0], 2'h1});
            wr(`IDX_COUNT_LOW, 8'h5a);
            tick(2 * dv[i]);
            rc("count_low", `IDX_COUNT_LOW, 8'h02);
        end
        $display("done: suspend and prescaler");
        wr(`IDX_CONTROL_STATUS, 8'h01);
        wr(`IDX_COUNT_LOW, 8'h00);
        tick(254);
        rc("count_low", `IDX_COUNT_LOW, 8'hfe);
        tick(5);
        rc("count_high", `IDX_COUNT_HIGH, 8'h00);
        rc("count_low", `IDX_COUNT_LOW, 8'h03);
        rc("count_high", `IDX_COUNT_HIGH, 8'h01);
        $display("done: count snapshot");
        wr(`IDX_COUNT_LOW, 8'hff);
        tick(65535);
        rc("count_low", `IDX_COUNT_LOW, 8'hff);
        rc("count_high", `IDX_COUNT_HIGH, 8'hff);
        rc("ctl", `IDX_CONTROL_STATUS, 8'h01);
        tick(1);
        rc("count_low", `IDX_COUNT_LOW, 8'h00);
        rc("ctl", `IDX_CONTROL_STATUS, 8'h11);
        wr(`IDX_CONTROL_STATUS, 8'hf1);
        rc("ctl", `IDX_CONTROL_STATUS, 8'h11);
        @(posedge hclk);
        other_chan_events <= 2'h1;
        @(posedge hclk);
        other_chan_events <= 2'h2;
        @(posedge hclk);
        other_chan_events <= 2'h0;
        rc("ctl", `IDX_CONTROL_STATUS, 8'hd1);
        wr(`IDX_CONTROL_STATUS, 8'h41);
        rc("ctl", `IDX_CONTROL_STATUS, 8'h41);
        $display("done: wrap and flags");
        wr(`IDX_CONTROL_STATUS, 8'h02);
        wr(`IDX_CHAN_VALUE_LOW, 8'h04);
        wr(`IDX_CHAN_VALUE_HIGH, 8'h00);
        for (int i = 0; i < 7; i++) begin
            wr(`IDX_CHAN_CONTROL, {2'h1, codes[i], 3'h4});
            wr(`IDX_COUNT_LOW, 8'h00);
            tick(4);
            cbit("out_match", e1[i], chan_out);
            tick(1);
            cbit("out_zero", e2[i], chan_out);
        end
        rc("count_low", `IDX_COUNT_LOW, 8'h00);
        rc("ctl", `IDX_CONTROL_STATUS, 8'h32);
        cbit("chan_oe", 1'h1, chan_oe);
        cbit("req", 1'h1, chan_zero_req);
        wr(`IDX_CHAN_CONTROL, 8'h2c);
        cbit("req", 1'h0, chan_zero_req);
        $display("done: modulo compare");
        wr(`IDX_CONTROL_STATUS, 8'h03);
        wr(`IDX_CHAN_VALUE_LOW, 8'h03);
        wr(`IDX_CHAN_VALUE_HIGH, 8'h00);
        wr(`IDX_COUNT_LOW, 8'h00);
        tick(5);
        rc("count_low", `IDX_COUNT_LOW, 8'h01);
        rc("ctl", `IDX_CONTROL_STATUS, 8'h03);
        tick(1);
        rc("ctl", `IDX_CONTROL_STATUS, 8'h33);
        tick(2);
        rc("count_low", `IDX_COUNT_LOW, 8'h02);
        $display("done: up/down");
        wr(`IDX_CONTROL_STATUS, 8'h01);
        wr(`IDX_COUNT_LOW, 8'h00);
        tick(42);
        for (int i = 0; i < 4; i++) begin
            wr(`IDX_CHAN_CONTROL, {6'h10, i[1:0]});
            wr(`IDX_CHAN_VALUE_LOW, 8'h00);
            wr(`IDX_CHAN_VALUE_HIGH, 8'h00);
            wr(`IDX_CONTROL_STATUS, 8'h01);
            cbit("chan_oe", 1'h0, chan_oe);
            @(posedge hclk);
            chan_in <= 1'h1;
            repeat (6) @(posedge hclk);
            rc("cap_rise", `IDX_CHAN_VALUE_LOW, i[0] ? 8'h2a : 8'h00);
            rc("flag_rise", `IDX_CONTROL_STATUS, i[0] ? 8'h21 : 8'h01);
            @(posedge hclk);
            chan_in <= 1'h0;
            repeat (6) @(posedge hclk);
            rc("cap_fall", `IDX_CHAN_VALUE_LOW, (i != 0) ? 8'h2a : 8'h00);
            rc("cap_high", `IDX_CHAN_VALUE_HIGH, 8'h00);
        end
        $display("done: capture");
        wrap_up();
    end
endmodule
